// ### include/mdc_pkg.sv
// constants, codes and register map shared by the motor driver control block
package mdc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
    localparam int ERR_HOLD_MS = 50;
    localparam int ERR_HOLD_CYC = ERR_HOLD_MS * 1000 * CLK_MHZ;
    localparam int STEP_US = 10;
    localparam int STEP_CYC = STEP_US * CLK_MHZ;
    localparam int NIN = 10;
    localparam int NOUT = 6;
    localparam int NOPD = 8;
    localparam int POS_W = 16;
    localparam int SYNC_W = 24;
    // factory positions of the switches, for reference by software
    localparam logic [3:0] UNIT_SW_RST = 4'h0;
    localparam logic [3:0] BAUD_SW_RST = 4'h7;
    localparam logic [1:0] FUNC_SW_RST = 2'h0;
    localparam logic [3:0] BAUD_NETCONV = 4'h7;
    // input function codes
    localparam logic [3:0] FI_START = 4'h1;
    localparam logic [3:0] FI_DSEL0 = 4'h2;
    localparam logic [3:0] FI_DSEL1 = 4'h3;
    localparam logic [3:0] FI_DSEL2 = 4'h4;
    localparam logic [3:0] FI_HOME = 4'h5;
    localparam logic [3:0] FI_STOP = 4'h6;
    localparam logic [3:0] FI_FREE = 4'h7;
    localparam logic [3:0] FI_ALMCLR = 4'h8;
    localparam logic [3:0] FI_FWD = 4'h9;
    localparam logic [3:0] FI_REV = 4'hA;
    localparam logic [3:0] FI_PRESET = 4'hF;
    // output function codes: 3 is pulse ready, which never drives
    localparam logic [3:0] FO_HOME_DONE = 4'h1;
    localparam logic [3:0] FO_IN_POS = 4'h2;
    localparam logic [3:0] FO_PULSE_RDY = 4'h3;
    localparam logic [3:0] FO_READY = 4'h4;
    localparam logic [3:0] FO_MOVE = 4'h5;
    localparam logic [3:0] FO_ALARM_NC = 4'h6;
    localparam logic [39:0] IN_MAP_RST = 40'hA986754321;
    localparam logic [23:0] OUT_MAP_RST = 24'h654321;
    // register byte offsets
    localparam logic [7:0] REG_IN_MAP_LO = 8'h00;
    localparam logic [7:0] REG_IN_MAP_HI = 8'h04;
    localparam logic [7:0] REG_OUT_MAP = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0C;
    localparam logic [7:0] REG_HOME_POS = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SWITCHES = 8'h18;
    localparam logic [7:0] REG_OPDATA = 8'h20;
    localparam int CTL_ALARM_SET = 0;
    localparam int CTL_PRESET = 1;
    // positions in the synchroniser vector
    localparam int SY_UNIT = 10;
    localparam int SY_BAUD = 14;
    localparam int SY_FSW = 18;
    localparam int SY_CUT1 = 20;
    localparam int SY_CUT2 = 21;
    localparam int SY_TRIP = 22;
    localparam int SY_PRESET = 23;
endpackage

// ### include/mdc_motion_if.sv
// command and status bundle between control logic and motion engine
`timescale 1ns/1ns
interface mdc_motion_if;
    import mdc_pkg::*;
    logic go;
    logic [POS_W-1:0] target;
    logic jog_fwd;
    logic jog_rev;
    logic stop;
    logic enable;
    logic moving;
    logic done;
    logic [POS_W-1:0] position;
    logic phase_a;
    logic phase_b;
    modport ctrl (output go, target, jog_fwd, jog_rev, stop, enable,
        input moving, done, position, phase_a, phase_b);
    modport engine (input go, target, jog_fwd, jog_rev, stop, enable,
        output moving, done, position, phase_a, phase_b);
endinterface

// ### logic/mdc_motion.sv
// motion engine: positioning, jog, stop and quadrature feedback
`timescale 1ns/1ns
module mdc_motion (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, high
    mdc_motion_if.engine m // commands in, status out
);
    import mdc_pkg::*;

    typedef enum logic [1:0] {ME_IDLE, ME_POS, ME_JOG} mdc_mstate_t;
    typedef struct packed {
        mdc_mstate_t state;
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] tgt;
        logic [11:0] tick;
        logic jdir;
        logic done;
        logic pa;
        logic pb;
    } mdc_motion_st_t;

    mdc_motion_st_t q, n;
    logic step;
    logic halt;

    function automatic logic [POS_W-1:0] mdc_step(input logic [POS_W-1:0] p, input logic up);
        return up ? p + 16'h0001 : p - 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        n.done = 1'b0;
        step = (q.tick == 12'(STEP_CYC - 1));
        halt = m.stop | ~m.enable;
        n.tick = (q.state == ME_IDLE || step) ? 12'h000 : q.tick + 12'h001;
        case (q.state)
            ME_IDLE: begin
                if (!halt && m.go) begin
                    if (m.target == q.pos) begin
                        n.done = 1'b1;
                    end else begin
                        n.tgt = m.target;
                        n.state = ME_POS;
                    end
                end else if (!halt && (m.jog_fwd || m.jog_rev)) begin
                    n.jdir = m.jog_fwd;
                    n.state = ME_JOG;
                end
            end
            ME_POS: begin
                if (halt) begin
                    n.state = ME_IDLE;
                end else if (step) begin
                    n.pos = mdc_step(q.pos, $signed(q.tgt) > $signed(q.pos));
                    if (n.pos == q.tgt) begin
                        n.done = 1'b1;
                        n.state = ME_IDLE;
                    end
                end
            end
            ME_JOG: begin
                if (halt) begin
                    n.state = ME_IDLE;
                end else if (!(q.jdir ? m.jog_fwd : m.jog_rev)) begin
                    n.done = 1'b1;
                    n.state = ME_IDLE;
                end else if (step) begin
                    n.pos = mdc_step(q.pos, q.jdir);
                end
            end
            default: n.state = ME_IDLE;
        endcase
        // gray code of the low position bits gives two phases a quarter apart
        n.pa = n.pos[1];
        n.pb = n.pos[1] ^ n.pos[0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign m.moving = (q.state != ME_IDLE);
    assign m.done = q.done;
    assign m.position = q.pos;
    assign m.phase_a = q.pa;
    assign m.phase_b = q.pb;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_stop_halts;
        (m.moving && m.stop) |=> !m.moving;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("motion kept going after stop");

    property p_one_phase;
        (q.pos != $past(q.pos)) |-> ((q.pa != $past(q.pa)) != (q.pb != $past(q.pb)));
    endproperty
    a_one_phase: assert property (p_one_phase) else $error("feedback phases not in quadrature");

    property p_done_on_target;
        ($past(q.state) == ME_POS && m.done) |-> (q.pos == q.tgt);
    endproperty
    a_done_on_target: assert property (p_done_on_target) else $error("finished away from target");
endmodule

// ### logic/mdc_top.sv
// motor driver control logic: indicators, switches, discrete I/O, cutoff, APB registers
//
// Function
// - alarm indicator blinks while alarm latched
// - activity indicator lit during serial traffic
// - error indicator lit on bad received data
// - unit number taken from unit switch
// - rate switch decodes to baud or converter
// - function switch bit one extends axis number
// - function switch bit two picks protocol
// - start input begins positioning
// - three select inputs pick operating data
// - return home goes to stored home
// - jog inputs run forward or reverse
// - home done after home return completes
// - move output high while motor runs
// - position reached once operation finishes
// - ready only when operation can start
// - alarm output closed when no alarm
// - input and output functions are remappable
// - cutoff inputs stop motor in hardware
// - cutoff monitor on when both cutoffs off
`timescale 1ns/1ns
module mdc_top #(
    parameter int BLINK_CYCLES = mdc_pkg::BLINK_CYC, // half period of alarm blink
    parameter int ERR_HOLD_CYCLES = mdc_pkg::ERR_HOLD_CYC // error indicator stretch
) (
    input wire logic CLOCK, // 100 MHz
    input wire logic SYS_RST, // synchronous reset, high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic [mdc_pkg::NIN-1:0] IN_PINS, // discrete control inputs
    output logic [mdc_pkg::NOUT-1:0] OUT_PINS, // discrete status outputs
    input wire logic [3:0] UNIT_NUMBER_SWITCH, // rotary unit switch
    input wire logic [3:0] BAUD_RATE_SWITCH, // rotary rate switch
    input wire logic [1:0] FUNCTION_SWITCH, // dip switch, bit 0 is No.1
    input wire logic HOME_PRESET_SWITCH, // stores current position as home
    input wire logic CUTOFF_INPUT_ONE, // power cutoff 1, high = run allowed
    input wire logic CUTOFF_INPUT_TWO, // power cutoff 2, high = run allowed
    input wire logic PROTECT_TRIP, // protective function triggered
    input wire logic COMM_TX_ACTIVE, // serial transmitter busy
    input wire logic COMM_RX_ACTIVE, // serial receiver busy
    input wire logic COMM_RX_ERROR, // pulse: bad received data
    output logic SUPPLY_INDICATOR, // supply lamp
    output logic ALARM_INDICATOR, // alarm lamp, blinking
    output logic COMM_ACTIVITY_INDICATOR, // communication lamp
    output logic COMM_ERROR_INDICATOR, // communication error lamp
    output logic [3:0] UNIT_NUMBER, // serial unit number
    output logic [4:0] AXIS_NUMBER, // axis number
    output logic [17:0] BAUD_BPS, // selected rate, zero if unused code
    output logic NET_CONVERTER_MODE, // network converter operation
    output logic PROTOCOL_SELECT, // serial protocol choice
    output logic PHASE_A_FEEDBACK, // feedback phase A
    output logic PHASE_B_FEEDBACK, // feedback phase B
    output logic CUTOFF_MONITOR_OUTPUT, // on when both cutoffs off
    output logic MOTOR_EXCITE // power stage enable
);
    import mdc_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [15:0] fn_prev;
        logic [NIN-1:0][3:0] in_map;
        logic [NOUT-1:0][3:0] out_map;
        logic [NOPD-1:0][POS_W-1:0] opd;
        logic [POS_W-1:0] home_pos;
        logic home_set;
        logic homing;
        logic home_done;
        logic in_pos;
        logic alarm;
        logic [31:0] blink_cnt;
        logic blink;
        logic [31:0] err_cnt;
        logic err_led;
        logic act_led;
        logic supply_indicator;
        logic [NOUT-1:0] outp;
        logic [31:0] prdata;
        logic [3:0] unit;
        logic [4:0] axis;
        logic [17:0] bps;
        logic netc;
        logic proto;
        logic cutoff_monitor_output;
        logic excite;
    } mdc_top_st_t;

    mdc_top_st_t q, n;
    mdc_motion_if mi ();
    logic [15:0] fn;
    logic [15:0] rise;
    logic [15:0] ostat;
    logic [2:0] dsel;
    logic cut_ok;
    logic ready;
    logic start_go;
    logic home_go;
    logic wr;

    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mdc_in_fn(input logic [NIN-1:0][3:0] map, input logic [NIN-1:0] pins);
        logic [15:0] f;
        f = '0;
        for (int i = 0; i < NIN; i++) begin
            f[map[i]] = f[map[i]] | pins[i];
        end
        f[0] = 1'b0;
        return f;
    endfunction

    function automatic logic [17:0] mdc_baud_bps(input logic [3:0] code);
        case (code)
            4'h0: return 18'h02580; // 9600
            4'h1: return 18'h04B00; // 19200
            4'h2: return 18'h09600; // 38400
            4'h3: return 18'h0E100; // 57600
            4'h4: return 18'h1C200; // 115200
            4'h5: return 18'h38400; // 230400
            default: return 18'h00000;
        endcase
    endfunction

    function automatic logic mdc_reg_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= REG_SWITCHES || a[7:5] == REG_OPDATA[7:5]);
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        n.s1 = {HOME_PRESET_SWITCH, PROTECT_TRIP, CUTOFF_INPUT_TWO, CUTOFF_INPUT_ONE,
            FUNCTION_SWITCH, BAUD_RATE_SWITCH, UNIT_NUMBER_SWITCH, IN_PINS};
        n.s2 = q.s1;
        n.supply_indicator = 1'b1;
        // every control input is looked up through its function code
        fn = mdc_in_fn(q.in_map, q.s2[NIN-1:0]);
        fn[FI_PRESET] = q.s2[SY_PRESET];
        rise = fn & ~q.fn_prev;
        n.fn_prev = fn;
        dsel = {fn[FI_DSEL2], fn[FI_DSEL1], fn[FI_DSEL0]};

        // cutoff works on synchronised pins only, no software in the path
        cut_ok = q.s2[SY_CUT1] & q.s2[SY_CUT2];
        n.cutoff_monitor_output = ~q.s2[SY_CUT1] & ~q.s2[SY_CUT2];
        n.excite = cut_ok & ~fn[FI_FREE];
        ready = ~q.alarm & cut_ok & ~fn[FI_FREE] & ~fn[FI_STOP] & ~mi.moving & q.excite;

        start_go = rise[FI_START] & ready;
        home_go = rise[FI_HOME] & ready & q.home_set & ~start_go;
        mi.go = start_go | home_go;
        mi.target = home_go ? q.home_pos : q.opd[dsel];
        mi.jog_fwd = fn[FI_FWD] & ~fn[FI_REV] & (ready | mi.moving);
        mi.jog_rev = fn[FI_REV] & ~fn[FI_FWD] & (ready | mi.moving);
        mi.stop = fn[FI_STOP] | q.alarm | ~cut_ok;
        mi.enable = q.excite;

        // home done only follows a completed home return
        n.homing = home_go | (q.homing & mi.moving);
        if (mi.go || mi.moving) begin
            n.in_pos = 1'b0;
            n.home_done = 1'b0;
        end
        if (mi.done) begin
            n.in_pos = 1'b1;
            n.home_done = q.homing;
        end

        // alarm: clear first so a trip in the same cycle wins
        if (rise[FI_ALMCLR]) begin
            n.alarm = 1'b0;
        end

        // register writes take effect in the access cycle
        wr = PSEL & PENABLE & PWRITE;
        if (wr) begin
            case (PADDR)
                REG_IN_MAP_LO: n.in_map[7:0] = PWDATA;
                REG_IN_MAP_HI: n.in_map[9:8] = PWDATA[7:0];
                REG_OUT_MAP: n.out_map = PWDATA[23:0];
                REG_CONTROL: begin
                    if (PWDATA[CTL_ALARM_SET]) begin
                        n.alarm = 1'b1;
                    end
                    if (PWDATA[CTL_PRESET]) begin
                        n.home_pos = mi.position;
                        n.home_set = 1'b1;
                    end
                end
                REG_HOME_POS: begin
                    n.home_pos = PWDATA[POS_W-1:0];
                    n.home_set = 1'b1;
                end
                default: begin
                    if (PADDR[7:5] == REG_OPDATA[7:5] && PADDR[1:0] == 2'h0) begin
                        n.opd[PADDR[4:2]] = PWDATA[POS_W-1:0];
                    end
                end
            endcase
        end
        if (rise[FI_PRESET]) begin
            n.home_pos = mi.position;
            n.home_set = 1'b1;
        end
        if (q.s2[SY_TRIP]) begin
            n.alarm = 1'b1;
        end

        // counter parks at its end while idle, so a new alarm lights the lamp at once
        if (!q.alarm) begin
            n.blink_cnt = 32'(BLINK_CYCLES - 1);
            n.blink = 1'b0;
        end else if (q.blink_cnt == BLINK_CYCLES - 1) begin
            n.blink_cnt = '0;
            n.blink = ~q.blink;
        end else begin
            n.blink_cnt = q.blink_cnt + 32'h1;
        end

        n.act_led = COMM_TX_ACTIVE | COMM_RX_ACTIVE;
        // error lamp is stretched so a one-cycle error is visible
        if (COMM_RX_ERROR) begin
            n.err_led = 1'b1;
            n.err_cnt = '0;
        end else if (q.err_led) begin
            if (q.err_cnt == ERR_HOLD_CYCLES - 1) begin
                n.err_led = 1'b0;
            end else begin
                n.err_cnt = q.err_cnt + 32'h1;
            end
        end

        // switch settings are live: a change shows three cycles later
        n.unit = q.s2[SY_UNIT+:4];
        n.axis = {q.s2[SY_FSW], q.s2[SY_UNIT+:4]};
        n.bps = mdc_baud_bps(q.s2[SY_BAUD+:4]);
        n.netc = (q.s2[SY_BAUD+:4] == BAUD_NETCONV);
        n.proto = q.s2[SY_FSW+1];

        ostat = '0;
        ostat[FO_HOME_DONE] = q.home_done;
        ostat[FO_IN_POS] = q.in_pos;
        ostat[FO_PULSE_RDY] = 1'b0;
        ostat[FO_READY] = ready;
        ostat[FO_MOVE] = mi.moving;
        ostat[FO_ALARM_NC] = ~q.alarm;
        for (int k = 0; k < NOUT; k++) begin
            n.outp[k] = ostat[q.out_map[k]];
        end

        // read data is captured in the setup cycle
        if (PSEL && !PENABLE) begin
            case (PADDR)
                REG_IN_MAP_LO: n.prdata = q.in_map[7:0];
                REG_IN_MAP_HI: n.prdata = {24'h000000, q.in_map[9:8]};
                REG_OUT_MAP: n.prdata = {8'h00, q.out_map};
                REG_HOME_POS: n.prdata = {16'h0000, q.home_pos};
                REG_STATUS: n.prdata = {mi.position, 8'h00, q.excite, q.cutoff_monitor_output, q.home_set,
                    q.alarm, ready, q.home_done, q.in_pos, mi.moving};
                REG_SWITCHES: n.prdata = {22'h000000, q.s2[SY_FSW+:2], q.s2[SY_BAUD+:4], q.s2[SY_UNIT+:4]};
                default: begin
                    if (mdc_reg_ok(PADDR) && PADDR >= REG_OPDATA) begin
                        n.prdata = {16'h0000, q.opd[PADDR[4:2]]};
                    end else begin
                        n.prdata = 32'h00000000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            q <= '0;
            q.in_map <= IN_MAP_RST;
            q.out_map <= OUT_MAP_RST;
        end else begin
            q <= n;
        end
    end

    mdc_motion u_motion (
        .clk(CLOCK),
        .rst(SYS_RST),
        .m(mi.engine)
    );

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mdc_reg_ok(PADDR);
    assign PRDATA = q.prdata;
    assign OUT_PINS = q.outp;
    assign SUPPLY_INDICATOR = q.supply_indicator;
    assign ALARM_INDICATOR = q.blink;
    assign COMM_ACTIVITY_INDICATOR = q.act_led;
    assign COMM_ERROR_INDICATOR = q.err_led;
    assign UNIT_NUMBER = q.unit;
    assign AXIS_NUMBER = q.axis;
    assign BAUD_BPS = q.bps;
    assign NET_CONVERTER_MODE = q.netc;
    assign PROTOCOL_SELECT = q.proto;
    assign PHASE_A_FEEDBACK = mi.phase_a;
    assign PHASE_B_FEEDBACK = mi.phase_b;
    assign CUTOFF_MONITOR_OUTPUT = q.cutoff_monitor_output;
    assign MOTOR_EXCITE = q.excite;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    property p_blink_off;
        !q.alarm |=> !ALARM_INDICATOR;
    endproperty
    a_blink_off: assert property (p_blink_off) else $error("alarm lamp lit without alarm");

    property p_blink_on;
        $rose(q.alarm) |=> ##1 ALARM_INDICATOR;
    endproperty
    a_blink_on: assert property (p_blink_on) else $error("alarm lamp did not light");

    property p_activity;
        (COMM_TX_ACTIVE || COMM_RX_ACTIVE) |=> COMM_ACTIVITY_INDICATOR;
    endproperty
    a_activity: assert property (p_activity) else $error("activity lamp missed traffic");

    property p_comm_err;
        COMM_RX_ERROR |=> COMM_ERROR_INDICATOR;
    endproperty
    a_comm_err: assert property (p_comm_err) else $error("error lamp missed bad data");

    property p_netconv;
        (q.s2[SY_BAUD+:4] == BAUD_NETCONV) |=> (NET_CONVERTER_MODE && BAUD_BPS == 18'h00000);
    endproperty
    a_netconv: assert property (p_netconv) else $error("converter setting misdecoded");

    property p_axis;
        AXIS_NUMBER[3:0] == UNIT_NUMBER;
    endproperty
    a_axis: assert property (p_axis) else $error("axis number disagrees with unit");

    sequence s_start_taken;
        rise[FI_START] && ready && (mi.target != mi.position);
    endsequence
    property p_start_moves;
        s_start_taken |=> mi.moving;
    endproperty
    a_start_moves: assert property (p_start_moves) else $error("start did not begin motion");

    property p_alarm_nc;
        q.alarm |-> ##[1:2] (q.out_map[5] != FO_ALARM_NC || !OUT_PINS[5]);
    endproperty
    a_alarm_nc: assert property (p_alarm_nc) else $error("alarm output stayed closed");

    property p_edm;
        (!q.s2[SY_CUT1] && !q.s2[SY_CUT2]) |=> CUTOFF_MONITOR_OUTPUT && !MOTOR_EXCITE;
    endproperty
    a_edm: assert property (p_edm) else $error("cutoff monitor wrong");

    property p_ready;
        (q.alarm || mi.moving) |-> !ready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready while busy or alarmed");
endmodule

// ### tb/mdc_plc.sv
// controller model driving the discrete control inputs
`timescale 1ns/1ns
module mdc_plc (
    input wire logic clk, // system clock
    input wire logic start, // start request
    input wire logic [2:0] sel, // operating data number
    input wire logic [5:0] misc, // levels of inputs 4 to 9
    output logic [9:0] pins = 10'h000 // discrete inputs of the driver
);
    // levels change only after an edge, like a real output card
    always @(posedge clk) begin
        pins <= {misc, sel, start};
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the motor driver control block
`timescale 1ns/1ns
module testbench;
    import mdc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, supply_indicator = 0, pready, pslverr, er, st = 0;
    logic hps = 0, cut1 = 1, cut2 = 1, trip = 0, tx = 0, rx = 0, rerr = 0;
    logic sup, alarm_indicator, act, cerr, netc, prot, pa, pb, mon, exc;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] sel = 3'h0;
    logic [5:0] misc = 6'h00, outp;
    logic [9:0] pins;
    logic [3:0] unit = 4'h0, baud = 4'h7, un;
    logic [1:0] fsw = 2'h0;
    logic [4:0] ax;
    logic [17:0] bps;
    int n_mismatch = 0, checked = 0;
    int rates[9] = '{9600, 19200, 38400, 57600, 115200, 230400, 0, 0, 0};
    always #5 clk = ~clk;
    mdc_plc plc (.clk(clk), .start(st), .sel(sel), .misc(misc), .pins(pins));
    mdc_top #(.BLINK_CYCLES(8), .ERR_HOLD_CYCLES(4)) dut (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(supply_indicator), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IN_PINS(pins), .OUT_PINS(outp), .UNIT_NUMBER_SWITCH(unit),
        .BAUD_RATE_SWITCH(baud), .FUNCTION_SWITCH(fsw), .HOME_PRESET_SWITCH(hps),
        .CUTOFF_INPUT_ONE(cut1), .CUTOFF_INPUT_TWO(cut2), .PROTECT_TRIP(trip), .COMM_TX_ACTIVE(tx),
        .COMM_RX_ACTIVE(rx), .COMM_RX_ERROR(rerr), .SUPPLY_INDICATOR(sup), .ALARM_INDICATOR(alarm_indicator),
        .COMM_ACTIVITY_INDICATOR(act), .COMM_ERROR_INDICATOR(cerr), .UNIT_NUMBER(un),
        .AXIS_NUMBER(ax), .BAUD_BPS(bps), .NET_CONVERTER_MODE(netc), .PROTOCOL_SELECT(prot),
        .PHASE_A_FEEDBACK(pa), .PHASE_B_FEEDBACK(pb), .CUTOFF_MONITOR_OUTPUT(mon),
        .MOTOR_EXCITE(exc));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer; waits on pready, unbounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        supply_indicator <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_switch;
        for (int b = 0; b < 9; b++) begin
            unit <= 4'h5;
            fsw <= 2'h3;
            baud <= b[3:0];
            cyc(5);
            chk(bps, rates[b]);
            chk(netc, b == 7);
        end
        chk(un, 4'h5);
        chk(ax, 5'h15);
        chk(prot, 1'b1);
        fsw <= 2'h0;
    endtask
    task automatic t_cut;
        cut1 <= 0;
        cyc(5);
        chk({mon, exc}, 2'b00);
        cut2 <= 0;
        cyc(5);
        chk(mon, 1'b1);
        cut1 <= 1;
        cut2 <= 1;
        misc <= 6'h02;
        cyc(5);
        chk({mon, exc}, 2'b00);
        misc <= 6'h00;
        cyc(5);
        chk(exc, 1'b1);
    endtask
    task automatic t_comm;
        tx <= 1;
        cyc(3);
        chk(act, 1'b1);
        tx <= 0;
        rx <= 1;
        rerr <= 1;
        cyc(1);
        rerr <= 0;
        cyc(2);
        chk({act, cerr}, 2'b11);
        rx <= 0;
        cyc(10);
        chk({act, cerr}, 2'b00);
    endtask
    // data word 3 holds target 2; select bits pick it at the start edge
    task automatic t_move;
        int n;
        apb(1, REG_OPDATA + 8'h0C, 32'h2);
        sel <= 3'h3;
        cyc(5);
        chk(outp[3], 1'b1);
        st <= 1;
        cyc(6);
        chk(outp[4:3], 2'b10);
        st <= 0;
        n = 0;
        while (outp[1] !== 1'b1 && n++ < 5000) @(posedge clk);
        chk(outp[4:1], 4'b0101);
        apb(0, REG_STATUS, 32'h0);
        chk(rd[31:16], 16'h2);
        chk({pa, pb}, 2'b11);
        apb(1, REG_OUT_MAP, 32'h654324);
        cyc(5);
        chk(outp[0], 1'b1);
        apb(0, 8'hFC, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask
    // preset home at 2, jog back one count, then return home
    task automatic t_home;
        hps <= 1;
        cyc(5);
        hps <= 0;
        misc <= 6'h20;
        cyc(1500);
        misc <= 6'h00;
        cyc(5);
        apb(0, REG_STATUS, 32'h0);
        chk(rd, 32'h000100AA);
        misc <= 6'h01;
        cyc(1020);
        misc <= 6'h00;
        cyc(5);
        apb(0, REG_STATUS, 32'h0);
        chk(rd, 32'h000200AE);
    endtask
    task automatic t_alarm;
        int tg;
        logic last;
        trip <= 1;
        cyc(1);
        trip <= 0;
        cyc(5);
        chk(outp[5], 1'b0);
        chk(outp[3], 1'b0);
        tg = 0;
        last = alarm_indicator;
        repeat (48) begin
            @(posedge clk);
            if (alarm_indicator !== last) tg++;
            last = alarm_indicator;
        end
        chk(tg >= 4, 1'b1);
        misc <= 6'h08;
        cyc(5);
        misc <= 6'h00;
        cyc(5);
        chk({outp[5], alarm_indicator}, 2'b10);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        rst <= 0;
        cyc(3);
        t_switch;
        t_cut;
        t_comm;
        t_move;
        t_home;
        t_alarm;
        end_sim;
    end
    // the tests need some 5000 cycles
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
endmodule
